// ==== design/svr_ref_ctrl.v ====
// Reference control for the core and bridge planes with an AXI4-Lite slave.
//
// Function
// - Pins are a boot code before host power-ok, a serial bus after it.
// - After reset, decode pin pair 00/01/10/11 as 1.1/1.0/0.9/0.8 V.
// - Enable rising edge latches boot code into holding register as target.
// - Soft-start steps both plane references toward boot target, never jumping.
// - Soft-start completion drives planes_power_good high.
// - With power-ok, decode set-VID commands and step addressed planes to code.
// - Core plane switched off keeps planes_power_good asserted.
// - Bridge plane stays active while core is off; off commands are ignored.
// - Power-ok loss steps both planes back to the held boot level.
// - Without power-ok after serial mode was first entered, pins are ignored and never resampled.
// - Power-ok return holds current levels until a fresh set-VID command.
// - Code zero is 1.55 V, minus 12.5 mV per step; 7C..7F mean off.
// - Data byte bit 7 is low_power_hint, low seven bits the voltage code.
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "svr_consts.vh"

module svr_ref_ctrl (
  // Clock and reset.
  input wire i_clk,
  input wire i_resetn,
  // Converter control pins.
  input wire i_enable,
  input wire i_host_power_ok,
  output reg o_planes_power_good,
  // Serial VID bus pins; data is open drain.
  input wire i_vid_bus_clock_pin,
  input wire i_vid_bus_data_pin,
  output reg o_vid_bus_data_pin,
  output reg o_vid_bus_data_pin_oe,
  // Reference targets towards the converters.
  output reg [6:0] o_core_ref_code,
  output reg [6:0] o_bridge_plane_ref_code,
  output reg o_core_off,
  output reg o_bridge_plane_off,
  output reg o_low_power_hint,
  // AXI4-Lite write channels.
  input wire [3:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  // AXI4-Lite read channels.
  input wire [3:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready
);

  // Soft-start begins this code; the step count is start minus boot code.
  parameter [6:0] SS_START_CODE = `SVR_SS_START_CODE;

  // --------------------------------------------------------------
  // States
  // --------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SOFT = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;

  reg [1:0] state;
  reg [1:0] en_sync;
  reg [1:0] pok_sync;
  reg [1:0] clk_sync;
  reg [1:0] dat_sync;
  reg en_prev;
  reg pok_prev;
  reg svi_seen;
  reg [1:0] boot_pins;
  reg [1:0] boot_latched;
  reg [6:0] boot_code;
  reg [6:0] core_target;
  reg [6:0] bridge_target;
  reg [15:0] step_div;
  reg [15:0] step_cnt;
  reg step_tick;
  reg [9:0] last_cmd;

  wire en_s = en_sync[1];
  wire pok_s = pok_sync[1];
  wire rx_update;
  wire rx_core_sel;
  wire rx_bridge_sel;
  wire [6:0] rx_code;
  wire rx_hint;
  wire rx_ack_oe;

  // Move one code toward a target; the reference never jumps.
  function [6:0] step_to;
    input [6:0] cur;
    input [6:0] tgt;
    begin
      if (cur < tgt) begin
        step_to = cur + 7'h01;
      end else if (cur > tgt) begin
        step_to = cur - 7'h01;
      end else begin
        step_to = cur;
      end
    end
  endfunction

  // Map the two-bit metal code onto a voltage code.
  function [6:0] boot_to_code;
    input [1:0] pins;
    begin
      case (pins)
        2'h0: boot_to_code = `SVR_BOOT_CODE_00;
        2'h1: boot_to_code = `SVR_BOOT_CODE_01;
        2'h2: boot_to_code = `SVR_BOOT_CODE_10;
        default: boot_to_code = `SVR_BOOT_CODE_11;
      endcase
    end
  endfunction

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------

  // Every pin passes two flops; only the second flop is read.
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      en_sync <= 2'h0;
      pok_sync <= 2'h0;
      clk_sync <= 2'h3;
      dat_sync <= 2'h3;
    end else begin
      en_sync <= {en_sync[0], i_enable};
      pok_sync <= {pok_sync[0], i_host_power_ok};
      clk_sync <= {clk_sync[0], i_vid_bus_clock_pin};
      dat_sync <= {dat_sync[0], i_vid_bus_data_pin};
    end
  end

  // --------------------------------------------------------------
  // Serial receiver
  // --------------------------------------------------------------

  // The receiver runs only with power-ok high in the run state; otherwise the bus is not decoded.
  svr_vid_rx u_rx (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_enable(pok_s & (state == ST_RUN)),
    .i_bus_clock(clk_sync[1]),
    .i_bus_data(dat_sync[1]),
    .o_update(rx_update),
    .o_core_sel(rx_core_sel),
    .o_bridge_sel(rx_bridge_sel),
    .o_voltage_code(rx_code),
    .o_low_power_hint(rx_hint),
    .o_ack_oe(rx_ack_oe)
  );

  // Open-drain data: the pin is only ever pulled low.
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      o_vid_bus_data_pin <= 1'b0;
      o_vid_bus_data_pin_oe <= 1'b0;
    end else begin
      o_vid_bus_data_pin <= 1'b0;
      o_vid_bus_data_pin_oe <= rx_ack_oe;
    end
  end

  // --------------------------------------------------------------
  // Step interval divider
  // --------------------------------------------------------------

  // One-cycle tick every step_div cycles; zero is treated as one.
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      step_cnt <= 16'h0000;
      step_tick <= 1'b0;
    end else if (step_cnt + 16'h0001 >= step_div) begin
      step_cnt <= 16'h0000;
      step_tick <= 1'b1;
    end else begin
      step_cnt <= step_cnt + 16'h0001;
      step_tick <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Boot code and sequencing
  // --------------------------------------------------------------

  // Boot pins are sampled only until the serial mode has been entered once.
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      boot_pins <= 2'h0;
      svi_seen <= 1'b0;
    end else begin
      if (pok_s && state == ST_RUN) begin
        svi_seen <= 1'b1;
      end
      if (!svi_seen && !pok_s) begin
        boot_pins <= {clk_sync[1], dat_sync[1]};
      end
    end
  end

  // Start-up, soft-start and serial stepping of both planes.
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
      en_prev <= 1'b0;
      pok_prev <= 1'b0;
      boot_latched <= 2'h0;
      boot_code <= `SVR_BOOT_CODE_00;
      core_target <= `SVR_BOOT_CODE_00;
      bridge_target <= `SVR_BOOT_CODE_00;
      o_core_ref_code <= SS_START_CODE;
      o_bridge_plane_ref_code <= SS_START_CODE;
      o_core_off <= 1'b1;
      o_bridge_plane_off <= 1'b1;
      o_planes_power_good <= 1'b0;
      o_low_power_hint <= 1'b1;
      last_cmd <= 10'h000;
    end else begin
      en_prev <= en_s;
      pok_prev <= pok_s;
      if (!en_s) begin
        state <= ST_IDLE;
        o_core_ref_code <= SS_START_CODE;
        o_bridge_plane_ref_code <= SS_START_CODE;
        o_core_off <= 1'b1;
        o_bridge_plane_off <= 1'b1;
        o_planes_power_good <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (!en_prev) begin
              // Once serial mode was seen the held code is reused as is.
              if (!svi_seen) begin
                boot_latched <= boot_pins;
                boot_code <= boot_to_code(boot_pins);
                core_target <= boot_to_code(boot_pins);
                bridge_target <= boot_to_code(boot_pins);
              end else begin
                core_target <= boot_code;
                bridge_target <= boot_code;
              end
              o_core_off <= 1'b0;
              o_bridge_plane_off <= 1'b0;
              state <= ST_SOFT;
            end
          end
          ST_SOFT: begin
            if (step_tick) begin
              o_core_ref_code <= step_to(o_core_ref_code, core_target);
              o_bridge_plane_ref_code <= step_to(o_bridge_plane_ref_code, bridge_target);
              if (o_core_ref_code == core_target &&
                  o_bridge_plane_ref_code == bridge_target) begin
                o_planes_power_good <= 1'b1;
                state <= ST_RUN;
              end
            end
          end
          ST_RUN: begin
            if (!pok_s) begin
              // Core plane is switched back on to regulate the boot level.
              core_target <= boot_code;
              bridge_target <= boot_code;
              o_core_off <= 1'b0;
              o_low_power_hint <= 1'b1;
            end else if (rx_update) begin
              last_cmd <= {rx_core_sel, rx_bridge_sel, rx_hint, rx_code};
              o_low_power_hint <= rx_hint;
              if (rx_core_sel) begin
                if (rx_code >= `SVR_OFF_CODE_MIN) begin
                  o_core_off <= 1'b1;
                end else begin
                  core_target <= rx_code;
                  o_core_off <= 1'b0;
                end
              end
              // An off code for the bridge plane is ignored.
              if (rx_bridge_sel && rx_code < `SVR_OFF_CODE_MIN) begin
                bridge_target <= rx_code;
              end
            end
            // Returning power-ok changes no target by itself.
            if (step_tick) begin
              o_core_ref_code <= step_to(o_core_ref_code, core_target);
              o_bridge_plane_ref_code <= step_to(o_bridge_plane_ref_code, bridge_target);
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------

  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [31:0] rd_word;
  reg rd_hit;

  // Address and data are taken in either order; response follows both.
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `SVR_RESP_OKAY;
      step_div <= `SVR_STEP_DIV_RST;
    end else begin
      o_s_axi_awready <= ~aw_held & ~o_s_axi_awready & ~o_s_axi_bvalid;
      o_s_axi_wready <= ~w_held & ~o_s_axi_wready & ~o_s_axi_bvalid;
      if (o_s_axi_awready && i_s_axi_awvalid) begin
        aw_held <= 1'b1;
        aw_addr <= i_s_axi_awaddr;
        o_s_axi_awready <= 1'b0;
      end
      if (o_s_axi_wready && i_s_axi_wvalid) begin
        w_held <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
        o_s_axi_wready <= 1'b0;
      end
      if (aw_held && w_held && !o_s_axi_bvalid) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        if (aw_addr == `SVR_REG_STEP_DIV) begin
          o_s_axi_bresp <= `SVR_RESP_OKAY;
          if (w_strb[0]) begin
            step_div[7:0] <= w_data[7:0];
          end
          if (w_strb[1]) begin
            step_div[15:8] <= w_data[15:8];
          end
        end else if (aw_addr == `SVR_REG_STATUS || aw_addr == `SVR_REG_REFS ||
                     aw_addr == `SVR_REG_LAST_CMD) begin
          o_s_axi_bresp <= `SVR_RESP_OKAY;
        end else begin
          o_s_axi_bresp <= `SVR_RESP_SLVERR;
        end
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode of the block's live state.
  always @* begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    case (i_s_axi_araddr)
      `SVR_REG_STATUS: begin
        rd_word[`SVR_ST_POWER_GOOD] = o_planes_power_good;
        rd_word[`SVR_ST_HOST_POWER_OK] = pok_s;
        rd_word[`SVR_ST_CORE_OFF] = o_core_off;
        rd_word[`SVR_ST_LOW_POWER_HINT] = o_low_power_hint;
        rd_word[`SVR_ST_SVI_MODE] = svi_seen;
        rd_word[`SVR_ST_STATE_LO +: 2] = state;
        rd_word[`SVR_ST_BOOT_LO +: 2] = boot_pins;
        rd_word[`SVR_ST_BOOT_LATCHED_LO +: 2] = boot_latched;
      end
      `SVR_REG_REFS: begin
        rd_word = {1'b0, bridge_target, 1'b0, core_target,
                   1'b0, o_bridge_plane_ref_code, 1'b0, o_core_ref_code};
      end
      `SVR_REG_STEP_DIV: begin
        rd_word = {16'h0000, step_div};
      end
      `SVR_REG_LAST_CMD: begin
        rd_word = {22'h000000, last_cmd};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel: one read at a time, data held until taken.
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= `SVR_RESP_OKAY;
    end else begin
      o_s_axi_arready <= ~o_s_axi_arready & ~o_s_axi_rvalid;
      if (o_s_axi_arready && i_s_axi_arvalid) begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= rd_word;
        o_s_axi_rresp <= rd_hit ? `SVR_RESP_OKAY : `SVR_RESP_SLVERR;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ==== inc/svr_consts.vh ====
// Constants for the serial VID reference control block.
`ifndef SVR_CONSTS_VH
`define SVR_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets on the AXI4-Lite slave
// ----------------------------------------------------------------
`define SVR_REG_STATUS 4'h0
`define SVR_REG_REFS 4'h4
`define SVR_REG_STEP_DIV 4'h8
`define SVR_REG_LAST_CMD 4'hC

// ----------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------
`define SVR_ST_POWER_GOOD 0
`define SVR_ST_HOST_POWER_OK 1
`define SVR_ST_CORE_OFF 2
`define SVR_ST_LOW_POWER_HINT 3
`define SVR_ST_SVI_MODE 4
`define SVR_ST_STATE_LO 8
`define SVR_ST_BOOT_LO 12
`define SVR_ST_BOOT_LATCHED_LO 16

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define SVR_STEP_DIV_RST 16'h0064
`define SVR_RESP_OKAY 2'h0
`define SVR_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Voltage codes: 1.5500 V at code zero, 12.5 mV lower per step
// ----------------------------------------------------------------
`define SVR_BOOT_CODE_00 7'h24
`define SVR_BOOT_CODE_01 7'h2C
`define SVR_BOOT_CODE_10 7'h34
`define SVR_BOOT_CODE_11 7'h3C
`define SVR_OFF_CODE_MIN 7'h7C
`define SVR_SS_START_CODE 7'h7B

// ----------------------------------------------------------------
// Serial VID bus framing
// ----------------------------------------------------------------
`define SVR_ADDR_PREFIX 5'h18
`define SVR_BITS_PER_BYTE 4'h8

`endif

// ==== design/svr_vid_rx.v ====
// Serial VID bus receiver that turns each set-VID frame into one update.
`timescale 1ns/1ns
`include "svr_consts.vh"

module svr_vid_rx (
  // Clock and reset.
  input wire i_clk,
  input wire i_resetn,
  // Synchronised bus levels and mode.
  input wire i_enable,
  input wire i_bus_clock,
  input wire i_bus_data,
  // Decoded update.
  output reg o_update,
  output reg o_core_sel,
  output reg o_bridge_sel,
  output reg [6:0] o_voltage_code,
  output reg o_low_power_hint,
  // Acknowledge drive on the data pin.
  output reg o_ack_oe
);

  reg clock_prev;
  reg data_prev;
  reg active;
  reg addr_ok;
  reg got_data;
  reg byte_idx;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;

  wire clock_rise = i_bus_clock & ~clock_prev;
  wire clock_fall = ~i_bus_clock & clock_prev;
  wire start_seen = i_bus_clock & clock_prev & data_prev & ~i_bus_data;
  wire stop_seen = i_bus_clock & clock_prev & ~data_prev & i_bus_data;

  // Frame decoder: address byte then data byte, each acknowledged.
  // A frame that is not addressed to us is dropped at its first byte.
  always @(posedge i_clk) begin
    o_update <= 1'b0;
    if (!i_resetn || !i_enable) begin
      clock_prev <= 1'b1;
      data_prev <= 1'b1;
      active <= 1'b0;
      addr_ok <= 1'b0;
      got_data <= 1'b0;
      byte_idx <= 1'b0;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      o_ack_oe <= 1'b0;
      o_core_sel <= 1'b0;
      o_bridge_sel <= 1'b0;
      o_voltage_code <= 7'h00;
      o_low_power_hint <= 1'b1;
    end else begin
      clock_prev <= i_bus_clock;
      data_prev <= i_bus_data;
      if (start_seen) begin
        active <= 1'b1;
        addr_ok <= 1'b0;
        got_data <= 1'b0;
        byte_idx <= 1'b0;
        bit_cnt <= 4'h0;
        o_ack_oe <= 1'b0;
      end else if (stop_seen) begin
        o_update <= active & got_data;
        active <= 1'b0;
        o_ack_oe <= 1'b0;
      end else if (active && clock_rise && bit_cnt != `SVR_BITS_PER_BYTE) begin
        shreg <= {shreg[6:0], i_bus_data};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (active && clock_fall) begin
        if (o_ack_oe) begin
          o_ack_oe <= 1'b0;
          bit_cnt <= 4'h0;
          byte_idx <= 1'b1;
        end else if (bit_cnt == `SVR_BITS_PER_BYTE) begin
          if (!byte_idx) begin
            if (shreg[7:3] == `SVR_ADDR_PREFIX && !shreg[0]) begin
              addr_ok <= 1'b1;
              o_core_sel <= shreg[2];
              o_bridge_sel <= shreg[1];
              o_ack_oe <= 1'b1;
            end else begin
              active <= 1'b0;
            end
          end else if (addr_ok && !got_data) begin
            o_low_power_hint <= shreg[7];
            o_voltage_code <= shreg[6:0];
            got_data <= 1'b1;
            o_ack_oe <= 1'b1;
          end else begin
            active <= 1'b0;
          end
        end
      end
    end
  end

endmodule

// ==== verification/svr_ref_ctrl_checker.sv ====
// Checker for the serial VID reference control block, bound to its top module.
`timescale 1ns/1ns
module svr_ref_ctrl_checker (
  // Clock and reset.
  input wire i_clk,
  input wire i_resetn,
  // Converter side.
  input wire i_enable,
  input wire o_planes_power_good,
  input wire o_vid_bus_data_pin,
  input wire o_vid_bus_data_pin_oe,
  input wire [6:0] o_core_ref_code,
  input wire [6:0] o_bridge_plane_ref_code,
  input wire o_core_off,
  input wire o_bridge_plane_off,
  // Register bus answers.
  input wire i_s_axi_bready,
  input wire o_s_axi_bvalid,
  input wire [1:0] o_s_axi_bresp,
  input wire i_s_axi_rready,
  input wire o_s_axi_rvalid
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // References move one code at a time while enabled, so no jump reaches the converter.
  a_core_one_step: assert property (i_enable [*4] ##0 $changed(o_core_ref_code)
    |-> (o_core_ref_code - $past(o_core_ref_code)) inside {7'h01, 7'h7F})
    else $error("core reference jumped");
  a_bridge_one_step: assert property (i_enable [*4] ##0 $changed(o_bridge_plane_ref_code)
    |-> (o_bridge_plane_ref_code - $past(o_bridge_plane_ref_code)) inside {7'h01, 7'h7F})
    else $error("bridge reference jumped");
  a_good_at_target: assert property ($rose(o_planes_power_good)
    |-> o_core_ref_code == o_bridge_plane_ref_code)
    else $error("power good rose before both planes met");
  a_good_needs_enable: assert property (!i_enable [*5] |-> !o_planes_power_good)
    else $error("power good high without enable");
  a_core_off_keeps_good: assert property ($past(o_planes_power_good) && i_enable
    && $rose(o_core_off) |-> o_planes_power_good)
    else $error("power good dropped with core off");
  a_bridge_stays_on: assert property (o_planes_power_good |-> !o_bridge_plane_off)
    else $error("bridge plane off while regulating");
  a_open_drain_low: assert property (o_vid_bus_data_pin_oe
    |-> !o_vid_bus_data_pin && o_planes_power_good)
    else $error("data pin driven outside serial mode");
  a_bresp_holds: assert property (o_s_axi_bvalid && !i_s_axi_bready
    |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response withdrawn");
  a_rvalid_holds: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid)
    else $error("read data withdrawn");

  // Main scenarios reached.
  c_good: cover property ($rose(o_planes_power_good));
  c_core_off: cover property (o_core_off && o_planes_power_good);
  c_ack: cover property ($rose(o_vid_bus_data_pin_oe));
endmodule

bind svr_ref_ctrl svr_ref_ctrl_checker u_chk (.*);

// ==== verification/svr_vid_host.sv ====
// Behavioural processor side of the serial VID pair.
`timescale 1ns/1ns
module svr_vid_host (
  // Levels driven onto the pair; data only ever pulled low.
  output reg o_clk_level,
  output reg o_data_low,
  // Resolved data wire.
  input wire i_data
);
  // Idle with clock high and data released; the clock stands still between frames.
  initial begin
    o_clk_level = 1'b1;
    o_data_low = 1'b0;
  end

  // Static boot code {clock, data} before power-ok.
  task set_boot(input [1:0] code);
    begin
      o_clk_level = code[1];
      o_data_low = !code[0];
    end
  endtask

  // One byte MSB first plus an acknowledge slot, at an 80 ns bit period.
  task send_byte(input [7:0] b, output ack);
    integer i;
    begin
      for (i = 7; i >= -1; i = i - 1) begin
        o_data_low = (i >= 0) ? !b[i] : 1'b0;
        #40 o_clk_level = 1'b1;
        #20 if (i < 0) ack = !i_data;
        #20 o_clk_level = 1'b0;
      end
    end
  endtask

  // START, address, data byte with the hint on top, STOP.
  task send_frame(input core, input bridge, input hint, input [6:0] code, output ok);
    reg a1;
    reg a2;
    begin
      #2 o_data_low = 1'b1;
      #40 o_clk_level = 1'b0;
      send_byte({5'h18, core, bridge, 1'b0}, a1);
      send_byte({hint, code}, a2);
      o_data_low = 1'b1;
      #40 o_clk_level = 1'b1;
      #40 o_data_low = 1'b0;
      #80 ok = a1 & a2;
    end
  endtask
endmodule

// ==== verification/serial_vid_reference_control_test.sv ====
// Self-checking bench for the serial VID reference control block.
`timescale 1ns/1ns
module serial_vid_reference_control_test;
  reg i_clk = 1'b0, i_resetn = 1'b0, i_enable = 1'b0, i_host_power_ok = 1'b0;
  reg [3:0] i_s_axi_awaddr = 4'h0, i_s_axi_araddr = 4'h0, i_s_axi_wstrb = 4'hF;
  reg [31:0] i_s_axi_wdata = 32'h0;
  reg i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  reg i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  wire o_planes_power_good, o_vid_bus_data_pin, o_vid_bus_data_pin_oe, o_core_off;
  wire o_bridge_plane_off, o_low_power_hint, o_s_axi_awready, o_s_axi_wready;
  wire o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, clk_lv, data_low;
  wire [6:0] o_core_ref_code, o_bridge_plane_ref_code;
  wire [1:0] o_s_axi_bresp, o_s_axi_rresp;
  wire [31:0] o_s_axi_rdata;
  // Pull-up on the open-drain data wire: low if either party pulls.
  wire i_vid_bus_data_pin = !(data_low || o_vid_bus_data_pin_oe);
  wire i_vid_bus_clock_pin = clk_lv;
  integer num_errors = 0, n_tests = 0, cyc = 0;
  reg [31:0] d;
  reg [1:0] r;
  reg ok;

  svr_ref_ctrl dut (.*);
  svr_vid_host host (.o_clk_level(clk_lv), .o_data_low(data_low), .i_data(i_vid_bus_data_pin));

  // Clock and a hang limit far above the few thousand cycles the tests need.
  always #5 i_clk = !i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      give_verdict;
    end
  end

  task check(input [8*12:1] name, input [31:0] exp, input [31:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s expected %0h seen %0h", name, exp, got);
      end
    end
  endtask

  // Register bus master: holds each channel until taken, waits for the answer.
  task axi_write(input [3:0] a, input [31:0] v);
    reg done;
    begin
      @(posedge i_clk);
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= v;
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid <= 1'b1;
      i_s_axi_bready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge i_clk);
        if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
        if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
        if (o_s_axi_bvalid) begin
          i_s_axi_bready <= 1'b0;
          r = o_s_axi_bresp;
          done = 1'b1;
        end
      end
    end
  endtask

  task axi_read(input [3:0] a);
    reg done;
    begin
      @(posedge i_clk);
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_rready <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge i_clk);
        if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
        if (o_s_axi_rvalid) begin
          i_s_axi_rready <= 1'b0;
          d = o_s_axi_rdata;
          r = o_s_axi_rresp;
          done = 1'b1;
        end
      end
    end
  endtask

  // Bounded wait for both references to reach the given codes.
  task wait_refs(input [6:0] c, input [6:0] b);
    integer k;
    begin
      for (k = 0; k < 600 && (o_core_ref_code !== c || o_bridge_plane_ref_code !== b); k = k + 1)
        @(posedge i_clk);
      check("core_ref", c, o_core_ref_code);
      check("bridge_ref", b, o_bridge_plane_ref_code);
    end
  endtask

  // Step divider reset value, write, readback, and a refused offset.
  task test_regs;
    begin
      axi_read(4'h8);
      check("step_div", 32'h64, d);
      axi_write(4'h8, 32'h2);
      check("wr_resp", 2'h0, r);
      axi_read(4'h8);
      check("step_div", 32'h2, d);
      axi_read(4'h2);
      check("bad_resp", 2'h2, r);
      $display("test_regs done");
    end
  endtask

  // Every boot code: latched at the enable edge, ramped, then power good.
  task test_boot;
    integer k, j;
    reg [6:0] e;
    begin
      for (k = 3; k >= 0; k = k - 1) begin
        e = (15500 - (11000 - 1000 * k)) / 125;
        @(posedge i_clk);
        i_enable <= 1'b0;
        host.set_boot(k[1:0]);
        repeat (8) @(posedge i_clk);
        i_enable <= 1'b1;
        repeat (8) @(posedge i_clk);
        host.set_boot(~k[1:0]);
        check("ss_busy", 0, o_planes_power_good);
        wait_refs(e, e);
        for (j = 0; j < 20 && o_planes_power_good !== 1'b1; j = j + 1) @(posedge i_clk);
        check("power_good", 1, o_planes_power_good);
        axi_read(4'h0);
        check("boot_latch", k, d[17:16]);
      end
      $display("test_boot done");
    end
  endtask

  // Commands for both planes, core off, and a refused bridge off.
  task test_cmds;
    begin
      host.set_boot(2'h3);
      @(posedge i_clk);
      i_host_power_ok <= 1'b1;
      repeat (10) @(posedge i_clk);
      host.send_frame(1'b1, 1'b1, 1'b0, 7'h30, ok);
      check("ack", 1, ok);
      wait_refs(7'h30, 7'h30);
      check("hint", 0, o_low_power_hint);
      host.send_frame(1'b1, 1'b0, 1'b1, 7'h7C, ok);
      repeat (20) @(posedge i_clk);
      check("core_off", 1, o_core_off);
      check("power_good", 1, o_planes_power_good);
      host.send_frame(1'b0, 1'b1, 1'b1, 7'h7E, ok);
      wait_refs(7'h30, 7'h30);
      check("bridge_off", 0, o_bridge_plane_off);
      $display("test_cmds done");
    end
  endtask

  // Power-ok loss returns to boot and ignores the pins; its return waits for a command.
  task test_pok;
    begin
      @(posedge i_clk);
      i_host_power_ok <= 1'b0;
      host.set_boot(2'h1);
      wait_refs(7'h24, 7'h24);
      check("core_off", 0, o_core_off);
      axi_read(4'h0);
      check("boot_latch", 0, d[17:16]);
      host.set_boot(2'h3);
      @(posedge i_clk);
      i_host_power_ok <= 1'b1;
      repeat (40) @(posedge i_clk);
      wait_refs(7'h24, 7'h24);
      host.send_frame(1'b0, 1'b1, 1'b1, 7'h40, ok);
      wait_refs(7'h24, 7'h40);
      $display("test_pok done");
    end
  endtask

  task give_verdict;
    begin
      $display("Checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // Reset for two cycles, then the scenarios in order.
  initial begin
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    test_regs;
    test_boot;
    test_cmds;
    test_pok;
    give_verdict;
  end
endmodule
